// File: rtl/ict_pkg.sv
// package: register map, field layout, reset values and loop constants
package ict_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_TRIM    = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_INT_STS = 8'h0C;
  localparam logic [7:0] OFS_INT_CLR = 8'h10;
  localparam logic [7:0] OFS_INT_EN  = 8'h14;
  localparam logic [7:0] OFS_CAP     = 8'h18;
  localparam logic [7:0] OFS_OFFSET  = 8'h1C;
  // ctrl fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MULT_LSB = 8;
  localparam int MULT_W        = 7;
  localparam logic             CTRL_EN_RST   = 1'b1;
  localparam logic [MULT_W-1:0] CTRL_MULT_RST = 7'h15;
  // trim and capacitor
  localparam logic [7:0] TRIM_RST        = 8'h80;
  localparam logic [9:0] CAP_FIXED_UNITS = 10'h180;
  localparam logic [9:0] CAP_TOTAL_UNITS = 10'h27F;
  // frequency shift per trim unit, in ppm of the unadjusted rate
  localparam logic [10:0] TRIM_STEP_PPM  = 11'h7A1;
  // status bits
  localparam int STS_CLK_STABLE = 0;
  localparam int STS_FLT_STABLE = 1;
  localparam int STS_RUNNING    = 2;
  localparam int STS_WAIT       = 3;
  // interrupt events
  localparam int EV_W           = 3;
  localparam int EV_CLK_STABLE  = 0;
  localparam int EV_FLT_STABLE  = 1;
  localparam int EV_FLT_LOST    = 2;
  // loop filter
  localparam logic [11:0] LF_RST      = 12'h400;
  localparam logic [3:0]  DIV_MAX     = 4'h9;
  localparam logic [11:0] STEP_FINE   = 12'h001;
  localparam logic [11:0] STEP_MID    = 12'h008;
  localparam logic [11:0] STEP_COARSE = 12'h020;
  // comparator error band: within 5, 5 to 15, above 15 percent
  typedef enum logic [1:0] {
    BAND_FINE   = 2'b00,
    BAND_MID    = 2'b01,
    BAND_COARSE = 2'b10,
    BAND_RSVD   = 2'b11
  } ict_band_e;
  localparam logic [3:0] SETTLE_SAMPLES = 4'h4;
endpackage : ict_pkg

// File: rtl/ict_loop_if.sv
// interface: loop filter and settle monitor signals
`timescale 1ns/10ps
interface ict_loop_if;
  logic        restart;
  logic        cmp_valid;
  logic        cmp_fast;
  logic [1:0]  cmp_band;
  logic [3:0]  div_sel;
  logic [7:0]  stage_sel;
  logic        filt_stable;
  logic        clk_stable;
  modport ctl  (output restart, output cmp_valid, output cmp_fast,
                output cmp_band, input div_sel, input stage_sel,
                input filt_stable, input clk_stable);
  modport filt (input cmp_valid, input cmp_fast, input cmp_band,
                output div_sel, output stage_sel, output filt_stable);
  modport mon  (input restart, input cmp_valid, input filt_stable,
                output clk_stable);
endinterface : ict_loop_if

// File: rtl/ict_loop_filter.sv
// loop filter: steers divider and stage selects from comparator bands
`timescale 1ns/10ps
module ict_loop_filter (
  input  wire logic pclk,
  input  wire logic presetn,
  ict_loop_if.filt  lp
);
  logic [11:0] acc_q;
  logic [11:0] step;
  logic        stable_q;

  always_comb begin
    unique case (ict_pkg::ict_band_e'(lp.cmp_band))
      ict_pkg::BAND_FINE: step = ict_pkg::STEP_FINE;
      ict_pkg::BAND_MID:  step = ict_pkg::STEP_MID;
      default:            step = ict_pkg::STEP_COARSE;
    endcase
  end

  // wraps past the ends on purpose; the divider field only clamps codes above 9 to 9
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= ict_pkg::LF_RST;
    end else if (lp.cmp_valid) begin
      acc_q <= lp.cmp_fast ? acc_q + step : acc_q - step;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_q <= 1'b0;
    end else if (lp.cmp_valid) begin
      stable_q <= (lp.cmp_band == ict_pkg::BAND_FINE);
    end
  end

  // divider codes above the slowest act as the slowest
  assign lp.div_sel     = (acc_q[11:8] > ict_pkg::DIV_MAX) ?
                          ict_pkg::DIV_MAX : acc_q[11:8];
  assign lp.stage_sel   = acc_q[7:0];
  assign lp.filt_stable = stable_q;
endmodule : ict_loop_filter

// File: rtl/ict_settle_mon.sv
// settle monitor: clock stable after a run of filter-stable samples
`timescale 1ns/10ps
module ict_settle_mon (
  input  wire logic pclk,
  input  wire logic presetn,
  ict_loop_if.mon   lp
);
  logic [3:0] run_q;
  logic       stable_q;

  // any disturbance restarts the settling interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 4'h0;
    end else if (lp.restart) begin
      run_q <= 4'h0;
    end else if (lp.cmp_valid) begin
      if (!lp.filt_stable) begin
        run_q <= 4'h0;
      end else if (run_q != ict_pkg::SETTLE_SAMPLES) begin
        run_q <= run_q + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_q <= 1'b0;
    end else begin
      stable_q <= !lp.restart && lp.filt_stable &&
                  (run_q == ict_pkg::SETTLE_SAMPLES);
    end
  end

  assign lp.clk_stable = stable_q;
endmodule : ict_settle_mon

// File: rtl/ict_clock_ctrl.sv
// top: trim, multiplier, settling and wait-mode control of the generator
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module ict_clock_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cpu_wait,
  input  wire logic        cpu_stop,
  input  wire logic        cmp_valid,
  input  wire logic        cmp_fast,
  input  wire logic [1:0]  cmp_band,
  output logic [7:0]       cap_switched_units,
  output logic             gen_run,
  output logic [3:0]       oscillator_divider_select,
  output logic [7:0]       oscillator_stage_select,
  output logic             clock_stable_flag,
  output logic             filter_stable_flag,
  output logic             irq,
  output logic             wake_req
);
  localparam int MW = ict_pkg::MULT_W;

  ict_loop_if lp ();

  logic                  en_q;
  logic [MW-1:0]         mult_q;
  logic [7:0]            trim_q;
  logic [ict_pkg::EV_W-1:0] ists_q;
  logic [ict_pkg::EV_W-1:0] ien_q;
  logic [ict_pkg::EV_W-1:0] ev;
  logic [ict_pkg::EV_W-1:0] clr;
  logic                  run_q;
  logic                  clk_st_q;
  logic                  flt_st_q;
  logic [31:0]           prdata_q;
  logic                  setup;
  logic                  access;
  logic                  wr;
  logic                  mapped;
  logic                  run;
  logic                  mult_chg;
  logic                  trim_chg;
  logic [9:0]            cap_total;
  logic signed [8:0]     trim_delta;
  logic signed [20:0]    offset_ppm;
  logic [31:0]           rd_mux;

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr     = access && pwrite;

  always_comb begin
    unique case (paddr)
      ict_pkg::OFS_CTRL, ict_pkg::OFS_TRIM, ict_pkg::OFS_STATUS,
      ict_pkg::OFS_INT_STS, ict_pkg::OFS_INT_CLR, ict_pkg::OFS_INT_EN,
      ict_pkg::OFS_CAP, ict_pkg::OFS_OFFSET: mapped = 1'b1;
      default:                               mapped = 1'b0;
    endcase
  end

  // read data captured in setup, so every access ends in one cycle
  assign pready  = access;
  assign pslverr = access && !mapped;

  ////////////////////////////////////////////////////////////////////////
  // control registers
  assign mult_chg = wr && (paddr == ict_pkg::OFS_CTRL) &&
                    (pwdata[ict_pkg::CTRL_MULT_LSB +: MW] != mult_q);
  assign trim_chg = wr && (paddr == ict_pkg::OFS_TRIM) &&
                    (pwdata[7:0] != trim_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q   <= ict_pkg::CTRL_EN_RST;
      mult_q <= ict_pkg::CTRL_MULT_RST;
    end else if (wr && paddr == ict_pkg::OFS_CTRL) begin
      en_q   <= pwdata[ict_pkg::CTRL_EN_BIT];
      mult_q <= pwdata[ict_pkg::CTRL_MULT_LSB +: MW];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_q <= ict_pkg::TRIM_RST;
    end else if (wr && paddr == ict_pkg::OFS_TRIM) begin
      trim_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_q <= '0;
    end else if (wr && paddr == ict_pkg::OFS_INT_EN) begin
      ien_q <= pwdata[ict_pkg::EV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // generator run state; wait does not stop it, stop does
  assign run = en_q && !cpu_stop;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run;
    end
  end

  // reset leaves run_q low, so the first run also counts as a re-enable
  assign lp.restart   = (run && !run_q) || mult_chg || trim_chg;
  assign lp.cmp_valid = cmp_valid && run;
  assign lp.cmp_fast  = cmp_fast;
  assign lp.cmp_band  = cmp_band;

  ict_loop_filter u_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .lp      (lp.filt)
  );

  ict_settle_mon u_settle (
    .pclk    (pclk),
    .presetn (presetn),
    .lp      (lp.mon)
  );

  ////////////////////////////////////////////////////////////////////////
  // capacitor and frequency offset
  // switched units equal the trim count, fixed units always present
  assign cap_total  = ict_pkg::CAP_FIXED_UNITS + {2'b00, trim_q};
  // more units lower the frequency, so the offset is default minus trim
  assign trim_delta = $signed({1'b0, ict_pkg::TRIM_RST}) -
                      $signed({1'b0, trim_q});
  // full swing of 128 steps reaches about 25 percent
  assign offset_ppm = 21'(trim_delta *
                      $signed({1'b0, ict_pkg::TRIM_STEP_PPM}));

  ////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_st_q <= 1'b0;
      flt_st_q <= 1'b0;
    end else begin
      clk_st_q <= lp.clk_stable;
      flt_st_q <= lp.filt_stable;
    end
  end

  assign ev[ict_pkg::EV_CLK_STABLE] = lp.clk_stable && !clk_st_q;
  assign ev[ict_pkg::EV_FLT_STABLE] = lp.filt_stable && !flt_st_q;
  assign ev[ict_pkg::EV_FLT_LOST]   = !lp.filt_stable && flt_st_q;
  assign clr = (wr && paddr == ict_pkg::OFS_INT_CLR) ?
               pwdata[ict_pkg::EV_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ists_q <= '0;
    end else begin
      ists_q <= (ists_q & ~clr) | ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      ict_pkg::OFS_CTRL: begin
        rd_mux[ict_pkg::CTRL_EN_BIT]            = en_q;
        rd_mux[ict_pkg::CTRL_MULT_LSB +: MW]    = mult_q;
      end
      ict_pkg::OFS_TRIM:    rd_mux[7:0] = trim_q;
      ict_pkg::OFS_STATUS: begin
        rd_mux[ict_pkg::STS_CLK_STABLE] = lp.clk_stable;
        rd_mux[ict_pkg::STS_FLT_STABLE] = lp.filt_stable;
        rd_mux[ict_pkg::STS_RUNNING]    = run_q;
        rd_mux[ict_pkg::STS_WAIT]       = cpu_wait;
        rd_mux[11:8]                    = lp.div_sel;
        rd_mux[23:16]                   = lp.stage_sel;
      end
      ict_pkg::OFS_INT_STS: rd_mux[ict_pkg::EV_W-1:0] = ists_q;
      ict_pkg::OFS_INT_EN:  rd_mux[ict_pkg::EV_W-1:0] = ien_q;
      ict_pkg::OFS_CAP: begin
        rd_mux[9:0]   = cap_total;
        rd_mux[25:16] = ict_pkg::CAP_TOTAL_UNITS;
      end
      ict_pkg::OFS_OFFSET:  rd_mux = {{11{offset_ppm[20]}}, offset_ppm};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata                    = prdata_q;
  assign cap_switched_units        = trim_q;
  assign gen_run                   = run_q;
  assign oscillator_divider_select = lp.div_sel;
  assign oscillator_stage_select   = lp.stage_sel;
  assign clock_stable_flag         = lp.clk_stable;
  assign filter_stable_flag        = lp.filt_stable;
  assign irq                       = |(ists_q & ien_q);
  assign wake_req                  = cpu_wait && irq;
endmodule : ict_clock_ctrl

// File: sim/ict_clock_ctrl_chk.sv
// checker: port-level relations of the clock trim and settle control
`timescale 1ns/10ps
module ict_clock_ctrl_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpu_wait,
  input wire logic        cpu_stop,
  input wire logic        cmp_valid,
  input wire logic [1:0]  cmp_band,
  input wire logic [7:0]  cap_switched_units,
  input wire logic        gen_run,
  input wire logic        clock_stable_flag,
  input wire logic        filter_stable_flag,
  input wire logic        irq,
  input wire logic        wake_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  wire twr = psel && penable && pwrite && paddr == ict_pkg::OFS_TRIM;
  wire cwr = psel && pwrite && paddr == ict_pkg::OFS_CTRL;
  // sample taken only while running; gen_run may lag a ctrl write
  wire smp = cmp_valid && gen_run && !cpu_stop;
  ////////////////////////////////////////////////////////////////////////////
  ready_now_a: assert property (pready == (psel && penable))
    else $error("pready not tied to access phase");
  err_in_ack_a: assert property (pslverr |-> pready)
    else $error("pslverr outside access phase");
  trim_load_a: assert property (
    twr |=> cap_switched_units == $past(pwdata[7:0]))
    else $error("trim units not loaded");
  trim_hold_a: assert property (
    !twr |=> $stable(cap_switched_units))
    else $error("trim units moved without write");
  trim_settle_a: assert property (
    twr && pwdata[7:0] != cap_switched_units |=> !clock_stable_flag)
    else $error("trim change kept clock stable");
  stop_halt_a: assert property (cpu_stop |=> !gen_run)
    else $error("generator runs in stop");
  wait_run_a: assert property (
    cpu_wait && !cpu_stop && gen_run && !cwr |=> gen_run)
    else $error("generator halted in wait");
  flt_set_a: assert property (smp && cmp_band == 2'h0 |=> filter_stable_flag)
    else $error("fine band did not set filter stable");
  flt_clr_a: assert property (smp && cmp_band != 2'h0 |=> !filter_stable_flag)
    else $error("coarse band kept filter stable");
  need_flt_a: assert property (
    !filter_stable_flag [*2] |-> !clock_stable_flag)
    else $error("clock stable without filter stable");
  wake_irq_a: assert property (wake_req == (cpu_wait && irq))
    else $error("wake request mismatch");
  cover property ($rose(clock_stable_flag));
  cover property (wake_req);
  cover property (pslverr);
  cover property (twr);
endmodule : ict_clock_ctrl_chk

bind ict_clock_ctrl ict_clock_ctrl_chk chk_u (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .cpu_wait,
  .cpu_stop, .cmp_valid, .cmp_band, .cap_switched_units, .gen_run,
  .clock_stable_flag, .filter_stable_flag, .irq, .wake_req);

// File: sim/test_internal_clock_trim_settling.sv
// testbench: apb trim, settling, interrupt and wait behaviour
`timescale 1ns/10ps
module test_internal_clock_trim_settling;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr, t, prev;
  logic [31:0] pwdata, prdata, rdata;
  logic        pready, pslverr, rerr, cpu_wait, cpu_stop;
  logic        cmp_valid, cmp_fast, irq, wake_req, gen_run, cs, fs;
  logic [1:0]  cmp_band;
  logic [7:0]  cap, stg;
  logic [3:0]  dv;
  int          error_cnt, check_count;
  ict_clock_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_wait(cpu_wait), .cpu_stop(cpu_stop), .cmp_valid(cmp_valid),
    .cmp_fast(cmp_fast), .cmp_band(cmp_band), .cap_switched_units(cap),
    .gen_run(gen_run), .oscillator_divider_select(dv),
    .oscillator_stage_select(stg), .clock_stable_flag(cs),
    .filter_stable_flag(fs), .irq(irq), .wake_req(wake_req));
  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  function logic [31:0] cap_exp(input logic [7:0] u);
    cap_exp = {6'h00, ict_pkg::CAP_TOTAL_UNITS, 6'h00,
               ict_pkg::CAP_FIXED_UNITS + {2'h0, u}};
  endfunction : cap_exp
  function logic [31:0] ofs_exp(input logic [7:0] u);
    ofs_exp = 32'((128 - int'(u)) * int'(ict_pkg::TRIM_STEP_PPM));
  endfunction : ofs_exp
  task cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task close_out;
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt
  // holds the whole request until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task sample(input logic [1:0] b, input logic f);
    @(posedge pclk);
    cmp_valid <= 1'b1; cmp_band <= b; cmp_fast <= f;
    @(posedge pclk);
    cmp_valid <= 1'b0;
  endtask : sample
  task settle;
    repeat (8) sample(2'h0, 1'($urandom));
    wt(3);
    cmp(cs, 1'b1);
    cmp(fs, 1'b1);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; cpu_wait = 0; cpu_stop = 0; cmp_valid = 0; cmp_fast = 0;
    cmp_band = 0; error_cnt = 0; check_count = 0;
    void'($urandom(66600));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wt(1);
    cmp(dv, 4'h4);
    cmp(stg, 8'h00);
    apb(1'b0, ict_pkg::OFS_TRIM, 32'h0);
    cmp(rdata, {24'h0, ict_pkg::TRIM_RST});
    apb(1'b0, ict_pkg::OFS_CAP, 32'h0);
    cmp(rdata, 32'h027F_0200);
    apb(1'b0, ict_pkg::OFS_OFFSET, 32'h0);
    cmp(rdata, 32'h0);
    settle;
    // both stable events latched, running, not waiting
    apb(1'b0, ict_pkg::OFS_INT_STS, 32'h0);
    cmp(rdata, 32'h0000_0003);
    apb(1'b0, ict_pkg::OFS_STATUS, 32'h0);
    cmp({28'h0, rdata[3:0]}, 32'h0000_0007);
    // interrupt: enable, wake from wait, then clear
    apb(1'b1, ict_pkg::OFS_INT_EN, 32'h1);
    wt(2);
    cmp(irq, 1'b1);
    cpu_wait <= 1'b1;
    wt(2);
    cmp(wake_req, 1'b1);
    cmp(gen_run, 1'b1);
    apb(1'b1, ict_pkg::OFS_INT_CLR, 32'h7);
    wt(2);
    cmp(wake_req, 1'b0);
    cpu_wait <= 1'b0;
    sample(2'h1, 1'b0);
    wt(1);
    cmp(fs, 1'b0);
    prev = 8'h80;
    // calibration-style trim sweep; no monitor, pulse is modelled by trim
    for (int i = 0; i < 6; i++) begin
      t = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      apb(1'b1, ict_pkg::OFS_TRIM, {24'h0, t});
      wt(2);
      cmp(cap, t);
      if (t != prev) cmp(cs, 1'b0);
      apb(1'b0, ict_pkg::OFS_CAP, 32'h0);
      cmp(rdata, cap_exp(t));
      apb(1'b0, ict_pkg::OFS_OFFSET, 32'h0);
      cmp(rdata, ofs_exp(t));
      prev = t;
      settle;
    end
    // multiplier lowered before stopping; monitor assumed off
    apb(1'b1, ict_pkg::OFS_CTRL, 32'h0000_0201);
    wt(2);
    cmp(cs, 1'b0);
    settle;
    cpu_stop <= 1'b1;
    wt(2);
    cmp(gen_run, 1'b0);
    cpu_stop <= 1'b0;
    wt(3);
    cmp(gen_run, 1'b1);
    cmp(cs, 1'b0);
    apb(1'b0, 8'h20, 32'h0);
    cmp(rerr, 1'b1);
    cmp(rdata, 32'h0);
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    cmp(rerr, 1'b1);
    apb(1'b0, ict_pkg::OFS_TRIM, 32'h0);
    cmp(rdata, {24'h0, prev});
    close_out();
  end
endmodule : test_internal_clock_trim_settling
